// [aps_pkg.sv]
package aps_pkg;
  // ==========================================================================
  // Timing
  localparam int ClkMhz = 40;
  localparam int PowerUpUs = 150;
  localparam int WakeUs = 150;
  localparam int SleepMinUs = 10;
  localparam int CfgWindowNs = 500;
  localparam int PowerUpCycles = PowerUpUs * ClkMhz;
  localparam int WakeCycles = WakeUs * ClkMhz;
  // Deep sleep entry: longer than the minimum, one cycle spare
  localparam int SleepCycles = SleepMinUs * ClkMhz + 1;
  // Config write must start well inside the window: round down, keep margin
  localparam int CfgDelayCycles = (CfgWindowNs * ClkMhz) / 2000;
  // Access strobe length, cycles
  localparam int StrobeCycles = 4;
  // ==========================================================================
  // Widths and fields
  localparam int AddrW = 20;
  localparam int DataW = 16;
  localparam int RegSelBit = 19;
  localparam int CfgW = 16;
  // ==========================================================================
  // Commands and sequencer states
  typedef enum logic [2:0] {
    APS_CMD_READ = 3'h0,
    APS_CMD_WRITE = 3'h1,
    APS_CMD_CONFIG = 3'h2,
    APS_CMD_SLEEP = 3'h3,
    APS_CMD_WAKE = 3'h4
  } aps_cmd_t;
  typedef enum logic [3:0] {
    APS_POWERUP = 4'h0,
    APS_IDLE = 4'h1,
    APS_SETUP = 4'h2,
    APS_STROBE = 4'h3,
    APS_HOLD = 4'h4,
    APS_CFG_WAIT = 4'h5,
    APS_SLEEP_WAIT = 4'h6,
    APS_SLEEPING = 4'h7,
    APS_WAKE_WAIT = 4'h8
  } aps_state_t;
endpackage

// [aps_tmr_if.sv]
`timescale 1ns/1ps
interface aps_tmr_if;
  logic load;
  logic [23:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// [aps_timer.sv]
`timescale 1ns/1ps
module aps_timer
  import aps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  aps_tmr_if.tmr t
);
  logic [23:0] cnt_q, cnt_d;
  logic done_q, done_d;
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (t.load) begin
      cnt_d = t.count;
    end else if (cnt_q != 24'h0) begin
      cnt_d = cnt_q - 24'h1;
      done_d = (cnt_q == 24'h1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q <= 24'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
  assign t.done = done_q;
endmodule

// [aps_host.sv]
`timescale 1ns/1ps
module aps_host
  import aps_pkg::*;
#(
  parameter int PowerUpWait = PowerUpCycles,
  parameter int WakeWait = WakeCycles
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmdValid,
  input wire aps_cmd_t cmdOp,
  input wire logic [AddrW-1:0] cmdAddr,
  input wire logic [DataW-1:0] cmdWdata,
  input wire logic [1:0] cmdByteEn,
  output logic cmdReady,
  output logic rdValid,
  output logic [DataW-1:0] rdData,
  output logic sleeping,
  output logic chip_select_n,
  output logic write_en_n,
  output logic output_en_n,
  output logic upper_byte_en_n,
  output logic lower_byte_en_n,
  output logic sleep_config_n,
  output logic [AddrW:0] memAddr,
  output logic [DataW-1:0] dqOut,
  output logic dqOe,
  input wire logic [DataW-1:0] dqIn
);
  // The shared 24-bit timer cannot serve longer waits
  if (PowerUpWait < 1 || PowerUpWait > 24'hffffff || WakeWait < 1 || WakeWait > 24'hffffff) begin
    $error("aps_host: wait counts out of range");
  end
  // ==========================================================================
  // Timer
  aps_tmr_if tIf ();
  aps_timer uTimer (.ref_clk(ref_clk), .rst_b(rst_b), .t(tIf));
  // ==========================================================================
  // Input synchronisers for read data
  logic [DataW-1:0] dqS1_q, dqS2_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dqS1_q <= 16'h0;
      dqS2_q <= 16'h0;
    end else begin
      dqS1_q <= dqIn;
      dqS2_q <= dqS1_q;
    end
  end
  // ==========================================================================
  // Sequencer
  aps_state_t st_q, st_d;
  aps_cmd_t op_q, op_d;
  logic [3:0] cnt_q, cnt_d;
  logic csN_q, csN_d, weN_q, weN_d, oeN_q, oeN_d, ubN_q, ubN_d, lbN_q, lbN_d, zzN_q, zzN_d;
  logic [AddrW:0] addr_q, addr_d;
  logic [DataW-1:0] dout_q, dout_d, rdat_q, rdat_d;
  logic oe_q, oe_d, rdy_q, rdy_d, rdv_q, rdv_d, slp_q, slp_d;
  logic tLoad;
  logic [23:0] tCount;
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    csN_d = csN_q;
    weN_d = weN_q;
    oeN_d = oeN_q;
    ubN_d = ubN_q;
    lbN_d = lbN_q;
    zzN_d = zzN_q;
    addr_d = addr_q;
    dout_d = dout_q;
    oe_d = oe_q;
    rdat_d = rdat_q;
    rdy_d = 1'b0;
    rdv_d = 1'b0;
    slp_d = slp_q;
    tLoad = 1'b0;
    tCount = 24'h0;
    unique case (st_q)
      APS_POWERUP: begin
        csN_d = 1'b1;
        if (tIf.done) begin
          st_d = APS_IDLE;
          rdy_d = 1'b1;
        end
      end
      APS_IDLE: begin
        rdy_d = 1'b1;
        if (cmdValid && rdy_q) begin
          rdy_d = 1'b0;
          op_d = cmdOp;
          // Bit 20 is driven low, never meaningful
          addr_d = {1'b0, cmdAddr};
          dout_d = cmdWdata;
          unique case (cmdOp)
            APS_CMD_READ, APS_CMD_WRITE: begin
              csN_d = 1'b0;
              ubN_d = ~cmdByteEn[1];
              lbN_d = ~cmdByteEn[0];
              oe_d = (cmdOp == APS_CMD_WRITE);
              cnt_d = 4'h1;
              st_d = APS_SETUP;
            end
            APS_CMD_CONFIG: begin
              // Only from idle, so no access can be in flight
              zzN_d = 1'b0;
              addr_d[RegSelBit] = 1'b0;
              cnt_d = 4'(CfgDelayCycles);
              st_d = APS_CFG_WAIT;
            end
            APS_CMD_SLEEP: begin
              csN_d = 1'b1;
              zzN_d = 1'b0;
              tLoad = 1'b1;
              tCount = 24'(SleepCycles);
              st_d = APS_SLEEP_WAIT;
            end
            default: begin
              rdy_d = 1'b1;
              st_d = APS_IDLE;
            end
          endcase
        end
      end
      APS_CFG_WAIT: begin
        if (cnt_q <= 4'h1) begin
          csN_d = 1'b0;
          cnt_d = 4'h1;
          st_d = APS_SETUP;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      APS_SETUP: begin
        // Select settles before the strobe; pins held at nop levels
        cnt_d = 4'(StrobeCycles);
        st_d = APS_STROBE;
        if (op_q == APS_CMD_READ) begin
          oeN_d = 1'b0;
        end else begin
          weN_d = 1'b0;
        end
      end
      APS_STROBE: begin
        if (cnt_q == 4'h1) begin
          if (op_q == APS_CMD_READ) begin
            rdat_d = dqS2_q;
          end
          // Raise strobe; data and address stay one more cycle
          weN_d = 1'b1;
          oeN_d = 1'b1;
          st_d = APS_HOLD;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      APS_HOLD: begin
        csN_d = 1'b1;
        ubN_d = 1'b1;
        lbN_d = 1'b1;
        oe_d = 1'b0;
        zzN_d = 1'b1;
        rdv_d = (op_q == APS_CMD_READ);
        st_d = APS_IDLE;
        rdy_d = 1'b1;
      end
      APS_SLEEP_WAIT: begin
        if (tIf.done) begin
          slp_d = 1'b1;
          st_d = APS_SLEEPING;
        end
      end
      APS_SLEEPING: begin
        rdy_d = 1'b1;
        // Ready must drop at once, or a request in the first wake cycle is lost
        if (cmdValid && rdy_q && cmdOp == APS_CMD_WAKE) begin
          rdy_d = 1'b0;
          zzN_d = 1'b1;
          slp_d = 1'b0;
          tLoad = 1'b1;
          tCount = 24'(WakeWait);
          st_d = APS_WAKE_WAIT;
        end
      end
      APS_WAKE_WAIT: begin
        if (tIf.done) begin
          st_d = APS_IDLE;
          rdy_d = 1'b1;
        end
      end
      default: begin
        st_d = APS_IDLE;
        csN_d = 1'b1;
      end
    endcase
  end
  // Timer armed once at reset release for power-up
  logic armed_q, armed_d;
  assign armed_d = 1'b1;
  assign tIf.load = tLoad || !armed_q;
  assign tIf.count = armed_q ? tCount : 24'(PowerUpWait);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q <= APS_POWERUP;
      op_q <= APS_CMD_READ;
      cnt_q <= 4'h0;
      csN_q <= 1'b1;
      weN_q <= 1'b1;
      oeN_q <= 1'b1;
      ubN_q <= 1'b1;
      lbN_q <= 1'b1;
      zzN_q <= 1'b1;
      addr_q <= 21'h0;
      dout_q <= 16'h0;
      oe_q <= 1'b0;
      rdat_q <= 16'h0;
      rdy_q <= 1'b0;
      rdv_q <= 1'b0;
      slp_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      csN_q <= csN_d;
      weN_q <= weN_d;
      oeN_q <= oeN_d;
      ubN_q <= ubN_d;
      lbN_q <= lbN_d;
      zzN_q <= zzN_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      rdat_q <= rdat_d;
      rdy_q <= rdy_d;
      rdv_q <= rdv_d;
      slp_q <= slp_d;
      armed_q <= armed_d;
    end
  end
  // ==========================================================================
  // Outputs, all registered
  assign cmdReady = rdy_q;
  assign rdValid = rdv_q;
  assign rdData = rdat_q;
  assign sleeping = slp_q;
  assign chip_select_n = csN_q;
  assign write_en_n = weN_q;
  assign output_en_n = oeN_q;
  assign upper_byte_en_n = ubN_q;
  assign lower_byte_en_n = lbN_q;
  assign sleep_config_n = zzN_q;
  assign memAddr = addr_q;
  assign dqOut = dout_q;
  assign dqOe = oe_q;
endmodule

// [aps_host_sva.sv]
`timescale 1ns/1ps
// ==========================================
// Pin protocol checks
module aps_host_sva
  import aps_pkg::*;
(
  input logic ref_clk,
  input logic rst_b,
  input logic cmdValid,
  input aps_cmd_t cmdOp,
  input logic cmdReady,
  input logic rdValid,
  input logic sleeping,
  input logic chip_select_n,
  input logic write_en_n,
  input logic output_en_n,
  input logic sleep_config_n,
  input logic [AddrW:0] memAddr,
  input logic [DataW-1:0] dqOut,
  input logic dqOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_read_pins: assert property (
    !output_en_n |-> !chip_select_n && write_en_n && sleep_config_n && !dqOe)
    else $error("read strobe with bad pins");
  chk_write_sel: assert property (!write_en_n |-> !chip_select_n)
    else $error("write strobe without select");
  chk_hold_data: assert property (
    $rose(write_en_n) && $past(sleep_config_n) |-> $past(dqOe) && $stable(dqOut))
    else $error("write data not held to strobe end");
  chk_addr_top: assert property (memAddr[AddrW] == 1'b0)
    else $error("unused address bit driven");
  chk_cfg_sel: assert property (
    !sleep_config_n && !chip_select_n |-> !memAddr[RegSelBit])
    else $error("config load with register select high");
  chk_cfg_idle: assert property ($fell(sleep_config_n) |-> $past(chip_select_n))
    else $error("config entry while access active");
  chk_sleep_pins: assert property (sleeping |-> chip_select_n && !sleep_config_n)
    else $error("deep sleep pins wrong");
  chk_read_lat: assert property (
    cmdValid && cmdReady && !sleeping && cmdOp == APS_CMD_READ |-> ##[4:12] rdValid)
    else $error("read data late");
  cover property (rdValid);
  cover property ($rose(sleeping));
  cover property (!sleep_config_n && !write_en_n);
endmodule
bind aps_host aps_host_sva u_sva (.ref_clk(ref_clk), .rst_b(rst_b), .cmdValid(cmdValid),
  .cmdOp(cmdOp), .cmdReady(cmdReady), .rdValid(rdValid), .sleeping(sleeping),
  .chip_select_n(chip_select_n), .write_en_n(write_en_n), .output_en_n(output_en_n),
  .sleep_config_n(sleep_config_n), .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe));

// [aps_mem_model.sv]
`timescale 1ns/1ps
// ==========================================
// Clockless memory device
module aps_mem_model
  import aps_pkg::*;
(
  input logic chip_select_n,
  input logic write_en_n,
  input logic output_en_n,
  input logic upper_byte_en_n,
  input logic lower_byte_en_n,
  input logic sleep_config_n,
  input logic [AddrW:0] memAddr,
  input logic [DataW-1:0] dqOut,
  output logic [DataW-1:0] dqIn,
  output logic [CfgW-1:0] cfgReg
);
  logic [DataW-1:0] mem [256];
  logic [DataW-1:0] lastDq = 16'h0000;
  logic wrOn = 1'b0;
  logic wrCfg;
  logic [1:0] wrBe;
  // Only level decode; no read path reaches cfgReg
  wire rdOn = !chip_select_n && write_en_n && !output_en_n && sleep_config_n;
  always @* begin
    if (rdOn) begin
      lastDq = mem[memAddr[7:0]];
    end
  end
  // Idle lanes show the inverse so stale data never matches
  always @* begin
    dqIn[15:8] = (rdOn && !upper_byte_en_n) ? lastDq[15:8] : ~lastDq[15:8];
    dqIn[7:0] = (rdOn && !lower_byte_en_n) ? lastDq[7:0] : ~lastDq[7:0];
  end
  always @(negedge chip_select_n, negedge write_en_n) begin
    if (!chip_select_n && !write_en_n) begin
      wrOn = 1'b1;
      wrCfg = !sleep_config_n;
      wrBe = {!upper_byte_en_n, !lower_byte_en_n};
    end
  end
  // First rising strobe ends the write; kept across deep sleep
  always @(posedge chip_select_n, posedge write_en_n, posedge upper_byte_en_n,
    posedge lower_byte_en_n) begin
    if (wrOn) begin
      wrOn = 1'b0;
      if (wrCfg && !memAddr[RegSelBit]) begin
        cfgReg = memAddr[15:0];
      end else if (!wrCfg) begin
        if (wrBe[1]) mem[memAddr[7:0]][15:8] = dqOut[15:8];
        if (wrBe[0]) mem[memAddr[7:0]][7:0] = dqOut[7:0];
      end
    end
  end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
// ==========================================
// Host controller bench
module testbench
  import aps_pkg::*;
;
  localparam int PuWait = 8;
  localparam int WkWait = 8;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmdValid = 1'b0;
  aps_cmd_t cmdOp = APS_CMD_READ;
  logic [AddrW-1:0] cmdAddr = 20'h00000;
  logic [DataW-1:0] cmdWdata = 16'h0000;
  logic [1:0] cmdByteEn = 2'h3;
  logic cmdReady, rdValid, sleeping, csN, weN, oeN, ubN, lbN, zzN, dqOe;
  logic [DataW-1:0] rdData, dqOut, dqIn, cfgReg;
  logic [AddrW:0] memAddr;
  int errors = 0;
  int checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  aps_host #(.PowerUpWait(PuWait), .WakeWait(WkWait)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdByteEn(cmdByteEn), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
    .sleeping(sleeping), .chip_select_n(csN), .write_en_n(weN), .output_en_n(oeN),
    .upper_byte_en_n(ubN), .lower_byte_en_n(lbN), .sleep_config_n(zzN),
    .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
  aps_mem_model u_mem (.chip_select_n(csN), .write_en_n(weN), .output_en_n(oeN),
    .upper_byte_en_n(ubN), .lower_byte_en_n(lbN), .sleep_config_n(zzN),
    .memAddr(memAddr), .dqOut(dqOut), .dqIn(dqIn), .cfgReg(cfgReg));
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts cycles to ready; a hang ends the run
  task automatic wait_ready(input int limit, input bit deselect, output int n);
    for (n = 0; n < limit && cmdReady !== 1'b1; n++) begin
      if (deselect) begin
        check({15'h0000, csN}, 16'h0001);
      end
      @(posedge ref_clk);
      #2;
    end
    if (cmdReady !== 1'b1) begin
      check({15'h0000, cmdReady}, 16'h0001);
      end_of_test();
    end
  endtask
  task automatic issue(input aps_cmd_t op, input logic [19:0] a, input logic [15:0] d,
    input logic [1:0] be);
    int n;
    wait_ready(100, 1'b0, n);
    cmdOp = op;
    cmdAddr = a;
    cmdWdata = d;
    cmdByteEn = be;
    cmdValid = 1'b1;
    @(posedge ref_clk);
    #2;
    cmdValid = 1'b0;
    @(posedge ref_clk);
    #2;
  endtask
  task automatic read_check(input logic [19:0] a, input logic [1:0] be,
    input logic [15:0] exp, input logic [15:0] mask);
    int i;
    issue(APS_CMD_READ, a, 16'h0000, be);
    for (i = 0; i < 20 && rdValid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check({15'h0000, rdValid}, 16'h0001);
    if (rdValid !== 1'b1) begin
      end_of_test();
    end
    check(rdData & mask, exp & mask);
  endtask
  task automatic t_rw();
    issue(APS_CMD_WRITE, 20'h00012, 16'h1234, 2'h3);
    issue(APS_CMD_WRITE, 20'h00012, 16'hab99, 2'h2);
    read_check(20'h00012, 2'h3, 16'hab34, 16'hffff);
    read_check(20'h00012, 2'h1, 16'h0034, 16'h00ff);
    check({14'h0000, csN, dqOe}, 16'h0002);
    $display("test rw done");
  endtask
  task automatic t_config();
    int n;
    issue(APS_CMD_CONFIG, 20'h85a5a, 16'hffff, 2'h0);
    wait_ready(60, 1'b0, n);
    check(cfgReg, 16'h5a5a);
    read_check(20'h00012, 2'h3, 16'hab34, 16'hffff);
    $display("test config done");
  endtask
  task automatic t_sleep();
    int i;
    issue(APS_CMD_SLEEP, 20'h00000, 16'h0000, 2'h0);
    for (i = 0; i < 500 && sleeping !== 1'b1; i++) begin
      @(posedge ref_clk);
      #2;
    end
    check({15'h0000, sleeping}, 16'h0001);
    if (sleeping !== 1'b1) begin
      end_of_test();
    end
    // Sleep pin low from the take edge; must exceed the minimum hold
    check({15'h0000, i + 1 > SleepMinUs * ClkMhz}, 16'h0001);
    check({14'h0000, csN, zzN}, 16'h0002);
    issue(APS_CMD_READ, 20'h00012, 16'h0000, 2'h3);
    for (i = 0; i < 15 && rdValid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check({14'h0000, rdValid, sleeping}, 16'h0001);
    issue(APS_CMD_WAKE, 20'h00000, 16'h0000, 2'h0);
    wait_ready(100, 1'b1, i);
    check({15'h0000, i + 2 >= WkWait}, 16'h0001);
    check(cfgReg, 16'h5a5a);
    issue(APS_CMD_WRITE, 20'h00034, 16'hc3e1, 2'h3);
    read_check(20'h00034, 2'h3, 16'hc3e1, 16'hffff);
    $display("test sleep done");
  endtask
  initial begin
    int n;
    repeat (16) @(posedge ref_clk);
    #2;
    check({15'h0000, csN}, 16'h0001);
    rst_b = 1'b1;
    wait_ready(100, 1'b1, n);
    check({15'h0000, n >= PuWait}, 16'h0001);
    $display("test powerup done");
    t_rw();
    t_config();
    t_sleep();
    end_of_test();
  end
endmodule
